// *** verilog/mmd_defs.svh ***
/*
 memory map decoder constants: region bounds, register addresses, option bit positions.
 assumes inclusion by bare name from the package and the decoder.
*/
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

`define MMD_ADDR_W        13
`define MMD_IO_LAST       13'h001f
`define MMD_P0_RSV_FIRST  13'h0020
`define MMD_P0_RSV_LAST   13'h002f
`define MMD_P0_RAM_FIRST  13'h0030
`define MMD_P0_RAM_LAST   13'h004f
`define MMD_P0_PROM_LAST  13'h005f
`define MMD_BASE_RAM_LAST 13'h00ff
`define MMD_P1_RAM_FIRST  13'h0100
`define MMD_P1_RAM_LAST   13'h015f
`define MMD_BOOT_FIRST    13'h1f00
`define MMD_BOOT_LAST     13'h1fef
`define MMD_OPT_ADDR      13'h1fdf
`define MMD_FOPT1_ADDR    13'h1ff0
`define MMD_FOPT2_ADDR    13'h1ff1
`define MMD_BIT_P0_RAM    7
`define MMD_BIT_P1_RAM    6
`define MMD_BIT_SEC       3
`define MMD_BIT_IRQ_LVL   1
`define MMD_BIT_SPARE     2
`define MMD_SP_RESET      8'hff
`define MMD_PC_RESET      13'h0000
`define MMD_ONE13         13'h0001
`define MMD_ONE8          8'h01

`endif

// *** verilog/mmd_pkg.sv ***
/*
 memory map decoder types: target selection and bus request grouping.
 assumes mmd_defs.svh is on the include path.
*/
`include "mmd_defs.svh"

package mmd_pkg;

  typedef enum logic [6:0] {
    MMD_T_IO    = 7'h01,
    MMD_T_RAM   = 7'h02,
    MMD_T_PROM  = 7'h04,
    MMD_T_BOOT  = 7'h08,
    MMD_T_OPT   = 7'h10,
    MMD_T_FOPT  = 7'h20,
    MMD_T_RSV   = 7'h40
  } mmd_target_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mmd_req_t;

  typedef struct packed {
    logic [7:0]  opt;
    logic [7:0]  sp;
    logic [12:0] pc;
    logic        irq_once;
    mmd_target_t tgt;
    logic [12:0] local_addr;
    logic [7:0]  rdata;
  } mmd_state_t;

endpackage

// *** verilog/mmd_decoder.sv ***
/*
 memory map decoder for an 8-bit core with an 8 Kbyte space: selects one target per
 access, holds the option register, and keeps stack pointer and program counter
 bookkeeping. assumes core strobes are synchronous to clk_sys (bus clock) and that
 the targets return read data combinationally in the access cycle.
*/
// Contract
// - every 8K access selects exactly one target
// - registers use ordinary load and store cycles
// - lowest 32 bytes select register page
// - option and factory registers at fixed addresses
// - stack pointer decrements on push, increments on pull
// - stack lives in RAM
// - code from PROM, variables from RAM
// - program counter advances one per fetch
// - page zero select maps RAM at 0030
// - page one select maps RAM at 0100
// - any reset clears both RAM selects
// - 1F00-1FEF selects bootloader ROM, except 1FDF (option register)
`timescale 1ns/10ps
`include "mmd_defs.svh"

module mmd_decoder (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire mmd_pkg::mmd_req_t req,
  input  wire logic              push,
  input  wire logic              pull,
  input  wire logic              fetch,
  input  wire logic              pc_load,
  input  wire logic [12:0]       pc_value,
  input  wire logic [7:0]        sec_cell,
  input  wire logic [7:0]        factory_option_one,
  input  wire logic [7:0]        factory_option_two,
  input  wire logic [7:0]        io_rdata,
  input  wire logic [7:0]        ram_rdata,
  input  wire logic [7:0]        prom_rdata,
  input  wire logic [7:0]        boot_rdata,
  output logic [6:0]             target_reg,
  output logic [12:0]            local_addr_reg,
  output logic [7:0]             rdata_reg,
  output logic                   page_zero_ram_select,
  output logic                   page_one_ram_select,
  output logic                   irq_level_sense,
  output logic [7:0]             stack_ptr_reg,
  output logic [12:0]            prog_cnt_reg
);

  mmd_pkg::mmd_state_t  st_reg;
  mmd_pkg::mmd_state_t  st_next;
  logic [12:0]          a;
  mmd_pkg::mmd_target_t tgt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // inclusive on both ends, so each region reads as first..last
  function automatic logic in_span(input logic [12:0] ad,
                                   input logic [12:0] lo,
                                   input logic [12:0] hi);
    return (ad >= lo) && (ad <= hi);
  endfunction

  // one step of the 8-bit stack pointer; both strobes together cancel
  function automatic logic [7:0] step8(input logic [7:0] v,
                                       input logic       dn,
                                       input logic       up);
    logic [7:0] r;
    r = v;
    if (dn && !up)
      r = v - `MMD_ONE8;
    else if (up && !dn)
      r = v + `MMD_ONE8;
    return r;
  endfunction

  // a load wins over a fetch in the same cycle, as a jump replaces the next fetch
  function automatic logic [12:0] pc_step(input logic [12:0] pc,
                                          input logic        ld,
                                          input logic [12:0] value,
                                          input logic        inc);
    logic [12:0] r;
    r = pc;
    if (ld)
      r = value;
    else if (inc)
      r = pc + `MMD_ONE13;
    return r;
  endfunction

  // bits 5, 4 and 0 are never stored, so they read back as zero;
  // the security bit lives in a nonvolatile cell and is only shown here
  function automatic logic [7:0] opt_image(input logic [7:0] opt,
                                           input logic       sec);
    logic [7:0] r;
    r = '0;
    r[`MMD_BIT_P0_RAM]  = opt[`MMD_BIT_P0_RAM];
    r[`MMD_BIT_P1_RAM]  = opt[`MMD_BIT_P1_RAM];
    r[`MMD_BIT_SEC]     = sec;
    r[`MMD_BIT_SPARE]   = opt[`MMD_BIT_SPARE];
    r[`MMD_BIT_IRQ_LVL] = opt[`MMD_BIT_IRQ_LVL];
    return r;
  endfunction

  // level sense may only be cleared, and only by the first write after reset
  function automatic logic [7:0] opt_merge(input logic [7:0] opt,
                                           input logic [7:0] wd,
                                           input logic       once);
    logic [7:0] r;
    r = opt;
    r[`MMD_BIT_P0_RAM] = wd[`MMD_BIT_P0_RAM];
    r[`MMD_BIT_P1_RAM] = wd[`MMD_BIT_P1_RAM];
    r[`MMD_BIT_SPARE]  = wd[`MMD_BIT_SPARE];
    if (!once)
      r[`MMD_BIT_IRQ_LVL] = opt[`MMD_BIT_IRQ_LVL] & wd[`MMD_BIT_IRQ_LVL];
    return r;
  endfunction

  // read data of the addressed target; reserved and unknown codes read zero
  function automatic logic [7:0] read_pick(input mmd_pkg::mmd_target_t t,
                                           input logic [12:0]          ad,
                                           input logic [7:0]           opt_rd,
                                           input logic [7:0]           io_rd,
                                           input logic [7:0]           ram_rd,
                                           input logic [7:0]           prom_rd,
                                           input logic [7:0]           boot_rd,
                                           input logic [7:0]           fopt1_rd,
                                           input logic [7:0]           fopt2_rd);
    logic [7:0] r;
    case (t)
      mmd_pkg::MMD_T_IO:   r = io_rd;
      mmd_pkg::MMD_T_RAM:  r = ram_rd;
      mmd_pkg::MMD_T_PROM: r = prom_rd;
      mmd_pkg::MMD_T_BOOT: r = boot_rd;
      mmd_pkg::MMD_T_OPT:  r = opt_rd;
      mmd_pkg::MMD_T_FOPT: begin
        if (ad == `MMD_FOPT1_ADDR)
          r = fopt1_rd;
        else
          r = fopt2_rd;
      end
      mmd_pkg::MMD_T_RSV:  r = 8'h00;
      default:             r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic mmd_pkg::mmd_target_t decode(input logic [12:0] ad,
                                                  input logic        p0,
                                                  input logic        p1);
    mmd_pkg::mmd_target_t t;
    // whatever no region below claims is program memory
    t = mmd_pkg::MMD_T_PROM;
    if (ad <= `MMD_IO_LAST)
      t = mmd_pkg::MMD_T_IO;
    else if (p0 && in_span(ad, `MMD_P0_RSV_FIRST, `MMD_P0_RSV_LAST))
      t = mmd_pkg::MMD_T_RSV;
    else if (p0 && in_span(ad, `MMD_P0_RAM_FIRST, `MMD_P0_RAM_LAST))
      t = mmd_pkg::MMD_T_RAM;
    else if (ad <= `MMD_P0_PROM_LAST)
      t = mmd_pkg::MMD_T_PROM;
    else if (ad <= `MMD_BASE_RAM_LAST)
      t = mmd_pkg::MMD_T_RAM;
    else if (p1 && in_span(ad, `MMD_P1_RAM_FIRST, `MMD_P1_RAM_LAST))
      t = mmd_pkg::MMD_T_RAM;
    // the option register sits inside the boot range and takes precedence
    else if (ad == `MMD_OPT_ADDR)
      t = mmd_pkg::MMD_T_OPT;
    else if (ad == `MMD_FOPT1_ADDR || ad == `MMD_FOPT2_ADDR)
      t = mmd_pkg::MMD_T_FOPT;
    else if (in_span(ad, `MMD_BOOT_FIRST, `MMD_BOOT_LAST))
      t = mmd_pkg::MMD_T_BOOT;
    // one assignment per path keeps the code one-hot
    return t;
  endfunction

  // upper bits dropped on purpose so out-of-range addresses alias
  assign a = req.addr[12:0];
  assign tgt = decode(a, st_reg.opt[`MMD_BIT_P0_RAM], st_reg.opt[`MMD_BIT_P1_RAM]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next            = st_reg;
    st_next.tgt        = tgt;
    st_next.local_addr = a;
    // read data holds between reads so the core may pick it up late
    if (req.rd)
      st_next.rdata = read_pick(tgt, a, opt_image(st_reg.opt, sec_cell[`MMD_BIT_SEC]),
                                io_rdata, ram_rdata, prom_rdata, boot_rdata,
                                factory_option_one, factory_option_two);
    if (req.wr && tgt == mmd_pkg::MMD_T_OPT) begin
      st_next.opt      = opt_merge(st_reg.opt, req.wdata, st_reg.irq_once);
      st_next.irq_once = 1'b1;
    end
    st_next.sp = step8(st_reg.sp, push, pull);
    st_next.pc = pc_step(st_reg.pc, pc_load, pc_value, fetch);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.opt[`MMD_BIT_IRQ_LVL] <= 1'b1;
      st_reg.sp <= `MMD_SP_RESET;
      st_reg.pc <= `MMD_PC_RESET;
      st_reg.tgt <= mmd_pkg::MMD_T_IO;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, wired straight from the state register
  // ----------------------------------------------------------------
  always_comb begin
    target_reg           = st_reg.tgt;
    local_addr_reg       = st_reg.local_addr;
    rdata_reg            = st_reg.rdata;
    page_zero_ram_select = st_reg.opt[`MMD_BIT_P0_RAM];
    page_one_ram_select  = st_reg.opt[`MMD_BIT_P1_RAM];
    irq_level_sense      = st_reg.opt[`MMD_BIT_IRQ_LVL];
    stack_ptr_reg        = st_reg.sp;
    prog_cnt_reg         = st_reg.pc;
  end

endmodule

// *** sim/mmd_core_side.sv ***
/* target read data stand-in: each target answers with its own pattern of the address.
   assumes the address is the 13-bit aliased bus address. */
`timescale 1ns/10ps
module mmd_core_side (
  input  wire logic [12:0] addr,
  output logic      [7:0]  io_rdata,
  output logic      [7:0]  ram_rdata,
  output logic      [7:0]  prom_rdata,
  output logic      [7:0]  boot_rdata
);
  // distinct patterns so a wrong target select shows in rdata
  assign io_rdata   = addr[7:0];
  assign ram_rdata  = ~addr[7:0];
  assign prom_rdata = addr[7:0] ^ 8'h5a;
  assign boot_rdata = addr[7:0] ^ 8'ha5;
endmodule

// *** sim/mmd_decoder_sva.sv ***
/* decode, stack and counter properties on the decoder ports.
   assumes clk_sys rising edge and rst active high. */
`timescale 1ns/10ps
module mmd_chk (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire mmd_pkg::mmd_req_t req,
  input wire logic              push,
  input wire logic              pull,
  input wire logic              fetch,
  input wire logic              pc_load,
  input wire logic [7:0]        io_rdata,
  input wire logic [7:0]        factory_option_one,
  input wire logic [6:0]        target_reg,
  input wire logic [7:0]        rdata_reg,
  input wire logic              page_zero_ram_select,
  input wire logic              page_one_ram_select,
  input wire logic [7:0]        stack_ptr_reg,
  input wire logic [12:0]       prog_cnt_reg
);
  wire [12:0] a = req.addr[12:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence io_rd; req.rd && a <= 13'h001f; endsequence
  sequence p1_area; a >= 13'h0100 && a <= 13'h015f; endsequence
  chk_io_page: assert property (io_rd |=>
    target_reg == 7'h01 && rdata_reg == $past(io_rdata))
    else $error("io page decode");
  chk_opt_addr: assert property (a == 13'h1fdf |=> target_reg == 7'h10)
    else $error("option register decode");
  chk_fopt_read: assert property (req.rd && a == 13'h1ff0 |=>
    target_reg == 7'h20 && rdata_reg == $past(factory_option_one))
    else $error("factory option read");
  chk_boot_rom: assert property (a >= 13'h1f00 && a <= 13'h1fef && a != 13'h1fdf |=>
    target_reg == 7'h08)
    else $error("boot rom decode");
  chk_one_hot: assert property ($onehot(target_reg))
    else $error("target not one-hot");
  chk_stack_push: assert property (push && !pull |=>
    stack_ptr_reg == $past(stack_ptr_reg) - 8'h01)
    else $error("push step");
  chk_stack_pull: assert property (pull && !push |=>
    stack_ptr_reg == $past(stack_ptr_reg) + 8'h01)
    else $error("pull step");
  chk_pc_fetch: assert property (fetch && !pc_load |=>
    prog_cnt_reg == $past(prog_cnt_reg) + 13'h0001)
    else $error("fetch step");
  chk_p0_ram: assert property (page_zero_ram_select && a >= 13'h0030 && a <= 13'h004f |=>
    target_reg == 7'h02)
    else $error("page zero ram");
  chk_p1_map: assert property (p1_area |=>
    target_reg == ($past(page_one_ram_select) ? 7'h02 : 7'h04))
    else $error("page one map");
endmodule
bind mmd_decoder mmd_chk u_chk (.*);

// *** sim/memory_map_decoder_tb.sv ***
/* self-checking bench: reads every region in all four layouts, random stack and pc traffic.
   assumes mmd_pkg, the partner model and the checker are compiled first. */
`timescale 1ns/10ps
module memory_map_decoder_tb;
  logic clk_sys = 1'b0, rst = 1'b1, push = 1'b0, pull = 1'b0, fetch = 1'b0, pc_load = 1'b0;
  logic [12:0] pc_value = 13'h0000, pc, prog_cnt_reg, local_addr_reg;
  logic [7:0] sec_cell, factory_option_one, factory_option_two, sp, rdata_reg, stack_ptr_reg;
  logic [7:0] io_rdata, ram_rdata, prom_rdata, boot_rdata;
  logic [6:0] target_reg;
  logic page_zero_ram_select, page_one_ram_select, irq_level_sense, e0, e1;
  mmd_pkg::mmd_req_t req = '0;
  logic [27:0] q[$];
  logic [15:0] adr[12] = '{16'h0005, 16'he01f, 16'h0025, 16'h0035, 16'h004f, 16'h0060,
                           16'h0120, 16'ha160, 16'h1f10, 16'h1fdf, 16'h1ff0, 16'h1ff1};
  int fails = 0, total_checks = 0, seed = 32'ha1f4;
  mmd_decoder uut (.*);
  mmd_core_side core (.addr(req.addr[12:0]), .*);
  always #25 clk_sys = ~clk_sys;
  // ----------------
  // expectations
  // ----------------
  function automatic logic [6:0] exp_tgt(input logic [12:0] a);
    if (a <= 13'h001f) return 7'h01;
    if (a == 13'h1fdf) return 7'h10;
    if (a == 13'h1ff0 || a == 13'h1ff1) return 7'h20;
    if (a >= 13'h1f00 && a <= 13'h1fef) return 7'h08;
    if (e0 && a <= 13'h002f) return 7'h40;
    if ((e0 && a <= 13'h004f) || (a >= 13'h0060 && a <= 13'h00ff)) return 7'h02;
    if (e1 && a >= 13'h0100 && a <= 13'h015f) return 7'h02;
    return 7'h04;
  endfunction
  function automatic logic [7:0] exp_dat(input logic [12:0] a);
    case (exp_tgt(a))
      7'h01: return a[7:0];
      7'h02: return ~a[7:0];
      7'h04: return a[7:0] ^ 8'h5a;
      7'h08: return a[7:0] ^ 8'ha5;
      7'h10: return {e0, e1, 2'h0, sec_cell[3], 3'h0};
      7'h20: return a[0] ? factory_option_two : factory_option_one;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input logic [15:0] a, input logic r, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req = '{a, r, w, d};
    if (r) q.push_back({exp_tgt(a[12:0]), exp_dat(a[12:0]), a[12:0]});
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk({page_zero_ram_select, page_one_ram_select, irq_level_sense}, 13'h1);
    chk(stack_ptr_reg, 13'h0ff);
    $display("reset test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (req.rd && !rst) begin
      #2;
      chk(target_reg, q[0][27:21]);
      chk(rdata_reg, q[0][20:13]);
      chk(local_addr_reg, q[0][12:0]);
      void'(q.pop_front());
    end
  end
  initial begin
    sec_cell = 8'($random(seed));
    factory_option_one = 8'($random(seed));
    factory_option_two = 8'($random(seed));
    do_reset();
    for (int c = 0; c < 4; c++) begin
      {e0, e1} = 2'(c);
      tick(16'h1fdf, 1'b0, 1'b1, {e0, e1, 6'h00});
      foreach (adr[i]) tick(adr[i], 1'b1, 1'b0, 8'h00);
      $display("layout %0d done", c);
    end
    tick(16'h0000, 1'b0, 1'b0, 8'h00);
    sp = 8'hff;
    pc = 13'h0000;
    repeat (60) begin
      @(posedge clk_sys);
      #1;
      chk(stack_ptr_reg, sp);
      chk(prog_cnt_reg, pc);
      {push, pull, fetch, pc_load} = 4'($random(seed));
      pc_value = 13'($random(seed));
      sp = sp + ((pull && !push) ? 8'h01 : 8'h00) - ((push && !pull) ? 8'h01 : 8'h00);
      pc = pc_load ? pc_value : pc + {12'h000, fetch};
    end
    @(posedge clk_sys);
    #1;
    chk(stack_ptr_reg, sp);
    chk(prog_cnt_reg, pc);
    {push, pull, fetch, pc_load} = 4'h0;
    $display("stack and pc test done");
    do_reset();
    tally_and_finish();
  end
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule
